/* File: hw/btbcc_pkg.sv */
// Constants and types shared by the bit-test branch and CPU control unit.
package btbcc_pkg;

   // ****************************************
   // Instruction and operand kinds
   // ****************************************
   typedef enum logic [3:0] {
      OP_NOP   = 4'h0,
      OP_SETBR = 4'h1,
      OP_CLRBR = 4'h2,
      OP_TCBR  = 4'h3,
      OP_DECBR = 4'h4,
      OP_IEN   = 4'h5,
      OP_IMSK  = 4'h6,
      OP_BANK  = 4'h7,
      OP_IDLE  = 4'h8,
      OP_DEEP  = 4'h9
   } btbcc_op_t;

   typedef enum logic [2:0] {
      K_NONE  = 3'h0,
      K_SHORT = 3'h1,
      K_SFR   = 3'h2,
      K_ACC   = 3'h3,
      K_PSW   = 3'h4,
      K_PTR   = 3'h5,
      K_REGB  = 3'h6,
      K_REGC  = 3'h7
   } btbcc_opnd_t;

   // ****************************************
   // Program status word layout
   // ****************************************
   localparam int unsigned PSW_IE   = 7;
   localparam int unsigned PSW_BK1  = 5;
   localparam int unsigned PSW_BK0  = 3;
   localparam logic [7:0]  PSW_RST  = 8'h00;

   // ****************************************
   // Instruction lengths in bytes
   // ****************************************
   localparam logic [2:0] LEN_1 = 3'h1;
   localparam logic [2:0] LEN_2 = 3'h2;
   localparam logic [2:0] LEN_3 = 3'h3;
   localparam logic [2:0] LEN_4 = 3'h4;

   // ****************************************
   // Cycle counts in processor clocks
   // ****************************************
   localparam logic [4:0] CYC_2  = 5'h02;
   localparam logic [4:0] CYC_4  = 5'h04;
   localparam logic [4:0] CYC_6  = 5'h06;
   localparam logic [4:0] CYC_8  = 5'h08;
   localparam logic [4:0] CYC_9  = 5'h09;
   localparam logic [4:0] CYC_10 = 5'h0A;
   localparam logic [4:0] CYC_11 = 5'h0B;
   localparam logic [4:0] CYC_12 = 5'h0C;
   // Extra cycles when code is not fetched from internal ROM.
   localparam logic [4:0] CYC_EXT_WAIT = 5'h02;
   localparam logic [4:0] CYC_ONE = 5'h01;

   localparam logic [7:0] BYTE_ONE  = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

/* File: hw/btbcc_cyc_timer.sv */
// Down counter that marks the last cycle of an instruction.
`timescale 1ns/100ps
`default_nettype none

module btbcc_cyc_timer
   import btbcc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       load,
   input  wire logic [4:0] loadVal,
   output logic            last
);

   logic [4:0] cnt_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 5'h00;
      end else if (load) begin
         cnt_r <= loadVal;
      end else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - CYC_ONE;
      end
   end

   assign last = (cnt_r == CYC_ONE);

endmodule

`default_nettype wire

/* File: hw/btbcc_exec.sv */
// Execution unit for bit-test branches, loop decrements and CPU control.
//
// Notes on behaviour
// RL1 - Set-branch short area: 3 bytes, 8/9 cycles.
// RL2 - Set-branch special register: 4 bytes, 11 cycles.
// RL3 - Set-branch accumulator bit: 3 bytes, 8 cycles.
// RL4 - Set-branch status word bit: 3 bytes, 9 cycles.
// RL5 - Set-branch pointer byte: 3 bytes, 10/11 cycles.
// RL6 - Clear-branch short area: 4 bytes, 10/11 cycles.
// RL7 - Clear-branch special register: 4 bytes, 11 cycles.
// RL8 - Clear-branch accumulator bit: 3 bytes, 8 cycles.
// RL9 - Clear-branch status word bit: 4 bytes, 11.
// RL10 - Clear-branch pointer byte: 3 bytes, 10/11 cycles.
// RL11 - Test-clear short area: 4 bytes, 10/12.
// RL12 - Test-clear special register: 4 bytes, 12 cycles.
// RL13 - Test-clear accumulator bit: 3 bytes, 8 cycles.
// RL14 - Test-clear status bit: 4 bytes, 12, flags change.
// RL15 - Test-clear pointer byte: 3 bytes, 10/12 cycles.
// RL16 - Decrement B or C, branch nonzero, 6.
// RL17 - Decrement short byte, branch nonzero, 8/10.
// RL18 - Interrupt enable sets flag, 2 bytes, 6.
// RL19 - Interrupt mask clears flag, 2 bytes, 6.
// RL20 - One counted cycle is one clock.
// RL21 - Longer count when operand outside fast RAM.
// RL22 - Counts hold only for internal ROM fetch.
// RL23 - Bank select writes bits; no-op changes nothing.
// RL24 - Idle and deep sleep requested after completion.
`timescale 1ns/100ps
`default_nettype none

module btbcc_exec
   import btbcc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire btbcc_op_t   opSel,
   input  wire btbcc_opnd_t opndSel,
   input  wire logic [2:0]  bitSel,
   input  wire logic [7:0]  memData,
   input  wire logic [7:0]  accData,
   input  wire logic [7:0]  regB,
   input  wire logic [7:0]  regC,
   input  wire logic [7:0]  relOffset,
   input  wire logic [15:0] pcIn,
   input  wire logic [1:0]  bankNum,
   input  wire logic        hsRam,
   input  wire logic        romFetch,
   output logic             busy_r,
   output logic             done_r,
   output logic             taken_r,
   output logic [15:0]      pcOut_r,
   output logic             wrEn_r,
   output btbcc_opnd_t      wrDest_r,
   output logic [7:0]       wrData_r,
   output logic [7:0]       psw_r,
   output logic             haltReq_r,
   output logic             stopReq_r
);

   // ****************************************
   // Length and timing tables
   // ****************************************
   function automatic logic [2:0] instrLen(btbcc_op_t op, btbcc_opnd_t k);
      logic [2:0] n;
      n = LEN_2;
      unique case (op)
         OP_SETBR: n = (k == K_SFR) ? LEN_4 : LEN_3;
         OP_CLRBR, OP_TCBR: n = (k == K_ACC || k == K_PTR) ? LEN_3 : LEN_4;
         OP_DECBR: n = (k == K_SHORT) ? LEN_3 : LEN_2;
         OP_NOP: n = LEN_1;
         OP_IEN, OP_IMSK, OP_BANK, OP_IDLE, OP_DEEP: n = LEN_2;
         default: n = LEN_1;
      endcase
      return n;
   endfunction

   function automatic logic [4:0] instrCyc(btbcc_op_t op, btbcc_opnd_t k,
                                           logic hs);
      logic [4:0] c;
      c = CYC_2;
      unique case (op)
         // RL1 RL4 RL5 set-branch timing
         OP_SETBR: begin
            unique case (k)
               K_SHORT: c = hs ? CYC_8 : CYC_9;
               K_SFR:   c = CYC_11;
               K_ACC:   c = CYC_8;
               K_PSW:   c = CYC_9;
               default: c = hs ? CYC_10 : CYC_11;
            endcase
         end
         // RL6 RL7 RL9 RL10 clear-branch timing
         OP_CLRBR: begin
            unique case (k)
               K_ACC:   c = CYC_8;
               K_SFR:   c = CYC_11;
               K_PSW:   c = CYC_11;
               default: c = hs ? CYC_10 : CYC_11;
            endcase
         end
         // RL11 RL12 RL15 test-clear timing
         OP_TCBR: begin
            unique case (k)
               K_ACC:   c = CYC_8;
               K_SFR:   c = CYC_12;
               K_PSW:   c = CYC_12;
               default: c = hs ? CYC_10 : CYC_12;
            endcase
         end
         // RL16 decrement timing
         OP_DECBR: c = (k == K_SHORT) ? (hs ? CYC_8 : CYC_10) : CYC_6;
         OP_BANK:  c = CYC_4;
         OP_NOP:   c = CYC_2;
         // RL18 control timing
         OP_IEN, OP_IMSK, OP_IDLE, OP_DEEP: c = CYC_6;
         default:  c = CYC_2;
      endcase
      return c;
   endfunction

   // ****************************************
   // Operand evaluation at issue
   // ****************************************
   logic        accept;
   logic [7:0]  srcByte;
   logic        bitVal;
   logic [7:0]  decByte;
   logic [7:0]  clrByte;
   logic [2:0]  lenNow;
   logic [4:0]  cycNow;
   logic [15:0] fallPc;
   logic [15:0] targetPc;
   logic        takeNxt;
   logic        timerLast;

   assign accept = start && !busy_r;

   always_comb begin
      unique case (opndSel)
         K_ACC:   srcByte = accData;
         K_PSW:   srcByte = psw_r;
         K_REGB:  srcByte = regB;
         K_REGC:  srcByte = regC;
         default: srcByte = memData;
      endcase
   end

   assign bitVal  = srcByte[bitSel];
   assign decByte = srcByte - BYTE_ONE;
   assign clrByte = srcByte & ~(BYTE_ONE << bitSel);
   assign lenNow  = instrLen(opSel, opndSel);
   // RL21 fast RAM picks short count
   // RL22 extra wait outside ROM
   assign cycNow  = instrCyc(opSel, opndSel, hsRam)
                    + (romFetch ? 5'h00 : CYC_EXT_WAIT);
   assign fallPc  = pcIn + {13'h0000, lenNow};
   assign targetPc = fallPc + {{8{relOffset[7]}}, relOffset};

   always_comb begin
      unique case (opSel)
         // RL3 RL13 branch when set
         OP_SETBR, OP_TCBR: takeNxt = bitVal;
         // RL8 branch when bit clear
         OP_CLRBR: takeNxt = !bitVal;
         // RL17 branch on nonzero result
         OP_DECBR: takeNxt = (decByte != BYTE_ZERO);
         default:  takeNxt = 1'b0;
      endcase
   end

   // ****************************************
   // Pending results held while the count runs
   // ****************************************
   btbcc_op_t   opQ_r;
   btbcc_opnd_t kindQ_r;
   logic        takeQ_r;
   logic [15:0] pcQ_r;
   logic        wrQ_r;
   logic [7:0]  dataQ_r;
   logic [2:0]  bitQ_r;
   logic [1:0]  bankQ_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         opQ_r   <= OP_NOP;
         kindQ_r <= K_NONE;
         takeQ_r <= 1'b0;
         pcQ_r   <= 16'h0000;
         wrQ_r   <= 1'b0;
         dataQ_r <= 8'h00;
         bitQ_r  <= 3'h0;
         bankQ_r <= 2'h0;
      end else if (accept) begin
         opQ_r   <= opSel;
         kindQ_r <= opndSel;
         takeQ_r <= takeNxt;
         // RL2 relative to next instruction
         pcQ_r   <= takeNxt ? targetPc : fallPc;
         // RL15 clear tested bit in memory
         wrQ_r   <= (opSel == OP_DECBR) ||
                    (opSel == OP_TCBR && bitVal && opndSel != K_PSW);
         dataQ_r <= (opSel == OP_DECBR) ? decByte : clrByte;
         bitQ_r  <= bitSel;
         bankQ_r <= bankNum;
      end
   end

   // ****************************************
   // Cycle timing
   // ****************************************
   // RL20 one count per clock
   btbcc_cyc_timer u_timer (
      .clk     (clk),
      .rst     (rst),
      .load    (accept),
      .loadVal (cycNow - CYC_ONE),
      .last    (timerLast)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         busy_r <= accept || (busy_r && !timerLast);
         done_r <= busy_r && timerLast;
      end
   end

   // ****************************************
   // Commit at the last cycle
   // ****************************************
   logic commit;
   assign commit = busy_r && timerLast;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         taken_r  <= 1'b0;
         pcOut_r  <= 16'h0000;
         wrEn_r   <= 1'b0;
         wrDest_r <= K_NONE;
         wrData_r <= 8'h00;
      end else begin
         wrEn_r <= commit && wrQ_r;
         if (commit) begin
            taken_r  <= takeQ_r;
            pcOut_r  <= pcQ_r;
            wrDest_r <= kindQ_r;
            wrData_r <= dataQ_r;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         psw_r <= PSW_RST;
      end else if (commit) begin
         unique case (opQ_r)
            // RL18 interrupt flag set
            OP_IEN:  psw_r[PSW_IE] <= 1'b1;
            // RL19 interrupt flag cleared
            OP_IMSK: psw_r[PSW_IE] <= 1'b0;
            // RL23 bank bits written
            OP_BANK: begin
               psw_r[PSW_BK1] <= bankQ_r[1];
               psw_r[PSW_BK0] <= bankQ_r[0];
            end
            // RL14 status bit cleared in place
            OP_TCBR: begin
               if (kindQ_r == K_PSW && takeQ_r) begin
                  psw_r[bitQ_r] <= 1'b0;
               end
            end
            default: psw_r <= psw_r;
         endcase
      end
   end

   // RL24 low-power request after completion
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         haltReq_r <= 1'b0;
         stopReq_r <= 1'b0;
      end else begin
         haltReq_r <= commit && (opQ_r == OP_IDLE);
         stopReq_r <= commit && (opQ_r == OP_DEEP);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [4:0] measCyc_r;
   logic [4:0] expCyc_r;
   logic [15:0] fallQ_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         measCyc_r <= 5'h00;
         expCyc_r  <= 5'h00;
         fallQ_r   <= 16'h0000;
      end else if (accept) begin
         measCyc_r <= CYC_ONE;
         expCyc_r  <= cycNow;
         fallQ_r   <= fallPc;
      end else if (busy_r) begin
         measCyc_r <= measCyc_r + CYC_ONE;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_cycle_total: assert property ( // RL20
      done_r |-> measCyc_r == expCyc_r)
      else $error("instruction cycle count wrong");
   a_short_fast: assert property ( // RL1
      accept && opSel == OP_SETBR && opndSel == K_SHORT && hsRam
      && romFetch |=> !done_r [*7] ##1 done_r)
      else $error("short-area set-branch not 8 cycles");
   a_short_slow: assert property ( // RL21
      accept && opSel == OP_SETBR && opndSel == K_SHORT && !hsRam
      && romFetch |-> ##9 done_r)
      else $error("short-area set-branch not 9 cycles");
   a_rom_wait: assert property ( // RL22
      accept && opSel == OP_NOP && !romFetch |-> ##4 done_r)
      else $error("outside fetch wait missing");
   a_ie_set: assert property ( // RL18
      done_r && opQ_r == OP_IEN |-> psw_r[PSW_IE])
      else $error("interrupt flag not set");
   a_ie_clear: assert property ( // RL19
      done_r && opQ_r == OP_IMSK |-> !psw_r[PSW_IE])
      else $error("interrupt flag not cleared");
   a_bank_bits: assert property ( // RL23
      done_r && opQ_r == OP_BANK
      |-> {psw_r[PSW_BK1], psw_r[PSW_BK0]} == bankQ_r)
      else $error("bank bits not written");
   a_fall_pc: assert property ( // RL3
      done_r && !taken_r |-> pcOut_r == fallQ_r)
      else $error("fall-through address wrong");
   a_tc_write: assert property ( // RL11
      done_r && opQ_r == OP_TCBR && taken_r && kindQ_r != K_PSW
      |-> wrEn_r && !wrData_r[bitQ_r])
      else $error("tested bit not cleared");
   a_dec_write: assert property ( // RL16
      done_r && opQ_r == OP_DECBR
      |-> wrEn_r && taken_r == (wrData_r != BYTE_ZERO))
      else $error("decrement branch wrong");
   a_sleep_req: assert property ( // RL24
      haltReq_r || stopReq_r |-> done_r && $past(busy_r))
      else $error("low-power request outside completion");

   c_taken_set: cover property (done_r && opQ_r == OP_SETBR && taken_r);
   c_tc_psw: cover property (done_r && opQ_r == OP_TCBR
                             && kindQ_r == K_PSW && taken_r);
   c_dec_loop: cover property (done_r && opQ_r == OP_DECBR && !taken_r);
   c_halt: cover property (haltReq_r);

endmodule

`default_nettype wire

/* File: tb/tb_bit_test_branch_cpu_control.sv */
// Self-checking testbench for the bit-test branch and CPU control unit.
`timescale 1ns/100ps
`default_nettype none

module tb_bit_test_branch_cpu_control
   import btbcc_pkg::*;
   ();

   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   localparam logic [15:0] PC0 = 16'h12F8;
   localparam logic [7:0]  OFS = 8'h85;
   logic        clk;
   logic        rst;
   logic        start;
   btbcc_op_t   opSel;
   btbcc_opnd_t opndSel;
   logic [2:0]  bitSel;
   logic [7:0]  memData;
   logic [7:0]  accData;
   logic [7:0]  regB;
   logic [7:0]  regC;
   logic [7:0]  relOffset;
   logic [15:0] pcIn;
   logic [1:0]  bankNum;
   logic        hsRam;
   logic        romFetch;
   logic        busy_r;
   logic        done_r;
   logic        taken_r;
   logic [15:0] pcOut_r;
   logic        wrEn_r;
   btbcc_opnd_t wrDest_r;
   logic [7:0]  wrData_r;
   logic [7:0]  psw_r;
   logic        haltReq_r;
   logic        stopReq_r;
   logic [1:0]  bankSel;
   int          errTotal;
   int          samplesChecked;
   btbcc_opnd_t ks [4] = '{K_SHORT, K_SFR, K_ACC, K_PTR};

   btbcc_exec dut (
      .clk(clk), .rst(rst), .start(start), .opSel(opSel),
      .opndSel(opndSel), .bitSel(bitSel), .memData(memData),
      .accData(accData), .regB(regB), .regC(regC),
      .relOffset(relOffset), .pcIn(pcIn), .bankNum(bankNum),
      .hsRam(hsRam), .romFetch(romFetch), .busy_r(busy_r),
      .done_r(done_r), .taken_r(taken_r), .pcOut_r(pcOut_r),
      .wrEn_r(wrEn_r), .wrDest_r(wrDest_r), .wrData_r(wrData_r),
      .psw_r(psw_r), .haltReq_r(haltReq_r), .stopReq_r(stopReq_r)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ****************************************
   // Expected lengths, counts and checks
   // ****************************************
   function automatic logic [15:0] exp_len(btbcc_op_t o, btbcc_opnd_t k);
      case (o)
         OP_SETBR: return (k == K_SFR) ? 16'h0004 : 16'h0003;
         OP_CLRBR, OP_TCBR: begin
            return (k == K_ACC || k == K_PTR) ? 16'h0003 : 16'h0004;
         end
         OP_DECBR: return (k == K_SHORT) ? 16'h0003 : 16'h0002;
         OP_NOP: return 16'h0001;
         default: return 16'h0002;
      endcase
   endfunction

   function automatic logic [15:0] exp_cyc(btbcc_op_t o, btbcc_opnd_t k,
                                           logic hs, logic rom);
      logic [15:0] n;
      n = 16'h0006;
      case (o)
         OP_SETBR: begin
            case (k)
               K_SHORT: n = hs ? 16'h0008 : 16'h0009;
               K_SFR:   n = 16'h000B;
               K_ACC:   n = 16'h0008;
               K_PSW:   n = 16'h0009;
               default: n = hs ? 16'h000A : 16'h000B;
            endcase
         end
         OP_CLRBR: begin
            if (k == K_SHORT || k == K_PTR) n = hs ? 16'h000A : 16'h000B;
            else n = (k == K_ACC) ? 16'h0008 : 16'h000B;
         end
         OP_TCBR: begin
            if (k == K_SHORT || k == K_PTR) n = hs ? 16'h000A : 16'h000C;
            else n = (k == K_ACC) ? 16'h0008 : 16'h000C;
         end
         OP_DECBR: begin
            if (k == K_SHORT) n = hs ? 16'h0008 : 16'h000A;
         end
         OP_BANK: n = 16'h0004;
         OP_NOP:  n = 16'h0002;
         default: n = 16'h0006;
      endcase
      return rom ? n : n + 16'h0002;
   endfunction

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errTotal++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Runs one instruction and returns in its done cycle, pulses visible.
   task automatic do_instr(input btbcc_op_t o, input btbcc_opnd_t k,
                           input logic [2:0] b, input logic [7:0] v,
                           input logic hs, input logic rom, input logic tk);
      logic [15:0] n;
      logic [15:0] pcE;
      n = 16'h0001;
      pcE = PC0 + exp_len(o, k) + (tk ? {{8{OFS[7]}}, OFS} : 16'h0000);
      @(posedge clk);
      start <= 1'b1;
      opSel <= o;
      opndSel <= k;
      bitSel <= b;
      memData <= (k == K_SHORT || k == K_SFR || k == K_PTR) ? v : ~v;
      accData <= (k == K_ACC) ? v : ~v;
      regB <= (k == K_REGB) ? v : ~v;
      regC <= (k == K_REGC) ? v : ~v;
      bankNum <= bankSel;
      hsRam <= hs;
      romFetch <= rom;
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      while (done_r !== 1'b1 && n < 16'd40) begin
         cmp({15'h0000, busy_r}, 16'h0001);
         @(posedge clk);
         n++;
         @(negedge clk);
      end
      if (n >= 16'd40) begin
         errTotal++;
         report_and_stop();
      end else begin
         cmp(n, exp_cyc(o, k, hs, rom));
         cmp({15'h0000, taken_r}, {15'h0000, tk});
         cmp(pcOut_r, pcE);
         cmp({15'h0000, busy_r}, 16'h0000);
      end
   endtask

   task automatic chk_wr(input btbcc_opnd_t d, input logic [7:0] v);
      cmp({15'h0000, wrEn_r}, 16'h0001);
      cmp({13'h0000, wrDest_r}, {13'h0000, d});
      cmp({8'h00, wrData_r}, {8'h00, v});
   endtask

   task automatic chk_psw(input logic [7:0] e);
      cmp({8'h00, psw_r}, {8'h00, e});
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic sc_cpu_ctrl();
      do_instr(OP_IEN, K_NONE, 3'h0, 8'h00, 1'b1, 1'b1, 1'b0);
      chk_psw(8'h80);
      do_instr(OP_IMSK, K_NONE, 3'h0, 8'h00, 1'b1, 1'b1, 1'b0);
      chk_psw(8'h00);
      for (int i = 0; i < 4; i++) begin
         bankSel = i[1:0];
         do_instr(OP_BANK, K_NONE, 3'h0, 8'h00, 1'b1, 1'b1, 1'b0);
         chk_psw({2'b00, bankSel[1], 1'b0, bankSel[0], 3'b000});
      end
      do_instr(OP_NOP, K_NONE, 3'h0, 8'h00, 1'b1, 1'b1, 1'b0);
      chk_psw(8'h28);
      do_instr(OP_NOP, K_NONE, 3'h0, 8'h00, 1'b1, 1'b0, 1'b0);
      do_instr(OP_IDLE, K_NONE, 3'h0, 8'h00, 1'b1, 1'b1, 1'b0);
      cmp({14'h0000, haltReq_r, stopReq_r}, 16'h0002);
      do_instr(OP_DEEP, K_NONE, 3'h0, 8'h00, 1'b1, 1'b1, 1'b0);
      cmp({14'h0000, haltReq_r, stopReq_r}, 16'h0001);
   endtask

   task automatic sc_bit_branch();
      btbcc_op_t o;
      for (int p = 0; p < 2; p++) begin
         o = p ? OP_CLRBR : OP_SETBR;
         for (int i = 0; i < 4; i++) begin
            do_instr(o, ks[i], 3'h6, 8'h40, 1'b1, 1'b1, p == 0);
            do_instr(o, ks[i], 3'h6, 8'hBF, 1'b0, 1'b1, p == 1);
         end
         do_instr(o, K_PSW, 3'h5, 8'h00, 1'b1, 1'b1, p == 0);
         do_instr(o, K_PSW, 3'h1, 8'h00, 1'b1, 1'b1, p == 1);
      end
   endtask

   task automatic sc_test_clear();
      for (int i = 0; i < 4; i++) begin
         do_instr(OP_TCBR, ks[i], 3'h2, 8'h36, 1'b1, 1'b1, 1'b1);
         chk_wr(ks[i], 8'h32);
         do_instr(OP_TCBR, ks[i], 3'h3, 8'h32, 1'b0, 1'b1, 1'b0);
      end
      do_instr(OP_TCBR, K_PSW, 3'h3, 8'h00, 1'b1, 1'b1, 1'b1);
      cmp({15'h0000, wrEn_r}, 16'h0000);
      chk_psw(8'h20);
   endtask

   task automatic sc_dec_branch();
      do_instr(OP_DECBR, K_REGB, 3'h0, 8'h01, 1'b1, 1'b1, 1'b0);
      chk_wr(K_REGB, 8'h00);
      do_instr(OP_DECBR, K_REGC, 3'h0, 8'h00, 1'b1, 1'b1, 1'b1);
      chk_wr(K_REGC, 8'hFF);
      do_instr(OP_DECBR, K_SHORT, 3'h0, 8'h02, 1'b1, 1'b1, 1'b1);
      chk_wr(K_SHORT, 8'h01);
      do_instr(OP_DECBR, K_SHORT, 3'h0, 8'h01, 1'b0, 1'b1, 1'b0);
      chk_wr(K_SHORT, 8'h00);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      errTotal = 0;
      samplesChecked = 0;
      rst = 1'b1;
      start = 1'b0;
      opSel = OP_NOP;
      opndSel = K_NONE;
      bitSel = 3'h0;
      memData = 8'h00;
      accData = 8'h00;
      regB = 8'h00;
      regC = 8'h00;
      relOffset = OFS;
      pcIn = PC0;
      bankNum = 2'h0;
      hsRam = 1'b1;
      romFetch = 1'b1;
      bankSel = 2'h0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk_psw(8'h00);
      cmp({13'h0000, wrDest_r}, {13'h0000, K_NONE});
      cmp({14'h0000, busy_r, done_r}, 16'h0000);
      @(posedge clk);
      rst <= 1'b0;
      sc_cpu_ctrl();
      sc_bit_branch();
      sc_test_clear();
      sc_dec_branch();
      report_and_stop();
   end

endmodule

`default_nettype wire
